// ### rtl/cimd_map.vh
`ifndef CIMD_MAP_VH
`define CIMD_MAP_VH
// Contact input mode decoder constants
`define CIMD_CLK_HZ 40000000
`define CIMD_PERIOD_MS 50
`define CIMD_PERIOD_CYC 2000000
`define CIMD_NUM_W 2
`define CIMD_NUM_RST 2'h0
`define CIMD_METHOD_STATUS1 1'h0
`define CIMD_METHOD_STATUS2 1'h1
`define CIMD_COLOUR_MODE_CONTACT 8'h0A
`define CIMD_ZONE_LOCAL_PID 4'h5
`define CIMD_MSG_CHARS 20
`define CIMD_MSG_COUNT 4
`define CIMD_MSG_NONE 3'h0
`define CIMD_COLOUR_WHITE 1'h0
`define CIMD_COLOUR_RED 1'h1
`endif

// ### rtl/cimd_sync_edge.v
`timescale 1ns/1ps
`default_nettype none
module cimd_sync_edge #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire sample_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] sync1;
  reg [W-1:0] sync2;
  reg [W-1:0] cur;
  reg [W-1:0] prev;
  reg primed;

  // Previous sample starts at all-off so contacts already on at power-up give a rising edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= {W{1'b0}};
      sync2 <= {W{1'b0}};
      cur <= {W{1'b0}};
      prev <= {W{1'b0}};
      primed <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1 <= pin_i;
      sync2 <= sync1;
      if (sample_i)
      begin
        prev <= cur;
        cur <= sync2;
        primed <= 1'b1;
      end
    end
  end

  assign level_o = cur;
  assign rise_o = primed ? (cur & ~prev) : {W{1'b0}};
  assign fall_o = primed ? (~cur & prev) : {W{1'b0}};
endmodule // cimd_sync_edge
`default_nettype wire

// ### rtl/cimd_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "cimd_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RL1: Wait input held on holds segment switch
// RL2: Wait and sync hold only for synchronized
// RL3: Sync hold holds, locks key hold changes
// RL4: Auto/manual level, on locks key changes
// RL5: Tuning edges start and stop tuning
// RL6: Latch release rising edge clears alarm latches
// RL7: Backlight rise turns off, fall on
// RL8: Message rising edge shows stored message
// RL9: Display key erases shown message
// RL10: Colour input applies in colour mode 10
// RL11: Pattern start edge selects, off stops
// RL12: Encoding one pattern bits map 001..100
// RL13: Encoding one locks pattern changes when set
// RL14: Encoding one all off keeps pattern
// RL15: Unassigned select bits read as off
// RL16: Encoding two maps 000..011, always locked
// RL17: Encoding one PID bits map 001..100
// RL18: Encoding one locks PID changes when set
// RL19: Zone selection 5 drives local PID group
// RL20: Pulses last 50 ms at least
// RL21: Level input release restores original action
// RL22: Contact on at power-up counts rising
// RL23: Edges from consecutive period samples only
// RL24: Reset defaults pattern 1, PID group 1
module cimd_decoder #(
  parameter PERIOD_CYC = `CIMD_PERIOD_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wait_input_i,
  input wire sync_hold_input_i,
  input wire auto_manual_input_i,
  input wire tuning_start_stop_input_i,
  input wire latch_release_input_i,
  input wire backlight_input_i,
  input wire [3:0] message_interrupt_inputs_i,
  input wire value_colour_input_i,
  input wire [3:0] pattern_start_inputs_i,
  input wire [2:0] pattern_select_bits_i,
  input wire [2:0] pattern_select_assigned_i,
  input wire [2:0] pid_select_bits_i,
  input wire [2:0] pid_select_assigned_i,
  input wire synchronized_mode_i,
  input wire pattern_bit_method_i,
  input wire pid_bit_method_i,
  input wire [7:0] display_colour_mode_i,
  input wire [3:0] zone_pid_selection_i,
  input wire display_key_i,
  output reg segment_wait_o,
  output reg segment_hold_o,
  output wire key_hold_change_enable_o,
  output reg auto_mode_o,
  output wire key_auto_manual_enable_o,
  output reg tuning_start_o,
  output reg tuning_stop_o,
  output reg [1:0] tuning_group_o,
  output reg latch_clear_o,
  output reg backlight_on_o,
  output reg [2:0] message_shown_o,
  output reg colour_red_o,
  output reg [1:0] pattern_number_o,
  output reg program_run_o,
  output reg program_start_o,
  output wire key_pattern_change_enable_o,
  output reg [1:0] pid_group_o,
  output reg [1:0] local_pid_group_o,
  output wire key_pid_change_enable_o,
  output reg sample_tick_o
);
  // Packed contact order for the sampler
  localparam integer NIN = 22;
  localparam integer IX_KEY = 0;
  localparam integer IX_WAIT = 1;
  localparam integer IX_HOLD = 2;
  localparam integer IX_AUTO = 3;
  localparam integer IX_TUNE = 4;
  localparam integer IX_LATCH = 5;
  localparam integer IX_LIGHT = 6;
  localparam integer IX_MSG = 7;
  localparam integer IX_COLOUR = 11;
  localparam integer IX_START = 12;
  localparam integer IX_PAT = 16;
  localparam integer IX_PID = 19;
  localparam integer PERIOD_LAST_I = PERIOD_CYC - 1;
  localparam [21:0] PERIOD_LAST = PERIOD_LAST_I[21:0];

  reg [21:0] period_cnt;
  wire sample;
  wire [NIN-1:0] pins;
  wire [NIN-1:0] lvl;
  wire [NIN-1:0] rise;
  wire [NIN-1:0] fall;
  wire [2:0] pat_bits;
  wire [2:0] pid_bits;
  reg [2:0] pat_dec;
  reg [2:0] pid_dec;
  reg [1:0] start_idx;
  reg start_hit;
  reg act_strobe;
  wire [1:0] active_pid;
  integer k;

  // 3-bit select decode; code 0 means no selection, else 4 plus the group number
  function [2:0] sel_decode;
    input method;
    input [2:0] b;
    begin
      if (method == `CIMD_METHOD_STATUS2)
      begin
        case (b) // [RL16]
          3'h0: sel_decode = 3'h4;
          3'h1: sel_decode = 3'h5;
          3'h2: sel_decode = 3'h6;
          3'h3: sel_decode = 3'h7;
          default: sel_decode = 3'h0;
        endcase
      end
      else
      begin
        case (b) // [RL12] [RL17]
          3'h1: sel_decode = 3'h4;
          3'h2: sel_decode = 3'h5;
          3'h3: sel_decode = 3'h6;
          3'h4: sel_decode = 3'h7;
          default: sel_decode = 3'h0;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Control period timebase; all contacts are judged once a period
  always @(posedge clk_i)
  begin
    if (rst_i)
      period_cnt <= 22'h000000;
    else if (ce_i)
    begin
      if (period_cnt == PERIOD_LAST)
        period_cnt <= 22'h000000;
      else
        period_cnt <= period_cnt + 22'h000001;
    end
  end

  assign sample = ce_i && (period_cnt == PERIOD_LAST);

  assign pins = {
    pid_select_bits_i,
    pattern_select_bits_i,
    pattern_start_inputs_i,
    value_colour_input_i,
    message_interrupt_inputs_i,
    backlight_input_i,
    latch_release_input_i,
    tuning_start_stop_input_i,
    auto_manual_input_i,
    sync_hold_input_i,
    wait_input_i,
    display_key_i
  };

  // The period-long sample spacing also filters bounce shorter than a period [RL20]
  cimd_sync_edge #(
    .W(NIN)
  ) i_cimd_sync_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sample_i(sample),
    .pin_i(pins),
    .level_o(lvl),
    .rise_o(rise), // [RL22] [RL23]
    .fall_o(fall)
  );

  assign pat_bits = lvl[IX_PAT + 2:IX_PAT] & pattern_select_assigned_i; // [RL15]
  assign pid_bits = lvl[IX_PID + 2:IX_PID] & pid_select_assigned_i; // [RL15]

  always @*
  begin
    pat_dec = sel_decode(pattern_bit_method_i, pat_bits);
    pid_dec = sel_decode(pid_bit_method_i, pid_bits);
    start_idx = 2'h0;
    start_hit = 1'b0;
    // Lowest numbered start input wins when several rise together
    for (k = 3; k >= 0; k = k - 1)
    begin
      if (rise[IX_START + k])
      begin
        start_idx = k[1:0];
        start_hit = 1'b1;
      end
    end
  end

  // Key and communication lockouts
  assign key_hold_change_enable_o = ~segment_hold_o; // [RL3]
  assign key_auto_manual_enable_o = ~auto_mode_o; // [RL4]
  assign key_pattern_change_enable_o = (pattern_bit_method_i == `CIMD_METHOD_STATUS1)
    && (pat_bits == 3'h0); // [RL13] [RL16]
  assign key_pid_change_enable_o = (pid_bit_method_i == `CIMD_METHOD_STATUS1)
    && (pid_bits == 3'h0); // [RL18] [RL16]

  // With zone selection 5 the local group is the one in use
  assign active_pid = (zone_pid_selection_i == `CIMD_ZONE_LOCAL_PID) ?
    local_pid_group_o : pid_group_o; // [RL19]

  ////////////////////////////////////////////////////////////////////////////////
  // Command state, updated in the cycle after a sample; the pulse outputs clear again on the next cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      segment_wait_o <= 1'b0;
      segment_hold_o <= 1'b0;
      auto_mode_o <= 1'b0;
      tuning_start_o <= 1'b0;
      tuning_stop_o <= 1'b0;
      tuning_group_o <= `CIMD_NUM_RST;
      latch_clear_o <= 1'b0;
      backlight_on_o <= 1'b1;
      message_shown_o <= `CIMD_MSG_NONE;
      colour_red_o <= `CIMD_COLOUR_WHITE;
      pattern_number_o <= `CIMD_NUM_RST; // [RL24]
      program_run_o <= 1'b0;
      program_start_o <= 1'b0;
      pid_group_o <= `CIMD_NUM_RST; // [RL24]
      local_pid_group_o <= `CIMD_NUM_RST; // [RL24]
      sample_tick_o <= 1'b0;
      act_strobe <= 1'b0;
    end
    else if (ce_i)
    begin
      tuning_start_o <= 1'b0;
      tuning_stop_o <= 1'b0;
      latch_clear_o <= 1'b0;
      program_start_o <= 1'b0;
      // Commands act one cycle after the sample so they see the fresh levels
      act_strobe <= sample;
      sample_tick_o <= act_strobe;
      if (act_strobe)
      begin
        // Level inputs follow the contact, so release restores the action [RL21]
        segment_wait_o <= synchronized_mode_i & lvl[IX_WAIT]; // [RL1] [RL2]
        segment_hold_o <= synchronized_mode_i & lvl[IX_HOLD]; // [RL3] [RL2]
        auto_mode_o <= lvl[IX_AUTO]; // [RL4]
        if (rise[IX_TUNE])
        begin
          tuning_start_o <= 1'b1; // [RL5]
          tuning_group_o <= active_pid; // [RL5]
        end
        if (fall[IX_TUNE])
          tuning_stop_o <= 1'b1; // [RL5]
        if (rise[IX_LATCH])
          latch_clear_o <= 1'b1; // [RL6]
        if (rise[IX_LIGHT])
          backlight_on_o <= 1'b0; // [RL7]
        else if (fall[IX_LIGHT])
          backlight_on_o <= 1'b1; // [RL7]
        // A new message outranks the key erase in the same period
        if (rise[IX_MSG])
          message_shown_o <= 3'h1; // [RL8]
        else if (rise[IX_MSG + 1])
          message_shown_o <= 3'h2; // [RL8]
        else if (rise[IX_MSG + 2])
          message_shown_o <= 3'h3; // [RL8]
        else if (rise[IX_MSG + 3])
          message_shown_o <= 3'h4; // [RL8]
        else if (rise[IX_KEY])
          message_shown_o <= `CIMD_MSG_NONE; // [RL9]
        if (display_colour_mode_i == `CIMD_COLOUR_MODE_CONTACT)
          colour_red_o <= lvl[IX_COLOUR] ? `CIMD_COLOUR_RED : `CIMD_COLOUR_WHITE; // [RL10]
        else
          colour_red_o <= `CIMD_COLOUR_WHITE;
        if (start_hit)
        begin
          pattern_number_o <= start_idx; // [RL11]
          program_run_o <= 1'b1; // [RL11]
          program_start_o <= 1'b1; // [RL11]
        end
        else if (program_run_o && !lvl[IX_START + pattern_number_o])
          program_run_o <= 1'b0; // [RL11]
        // Select bits cannot move the pattern under a running program
        else if (pat_dec[2] && !program_run_o)
          pattern_number_o <= pat_dec[1:0]; // [RL12] [RL14]
        if (pid_dec[2])
        begin
          pid_group_o <= pid_dec[1:0]; // [RL17]
          if (zone_pid_selection_i == `CIMD_ZONE_LOCAL_PID)
            local_pid_group_o <= pid_dec[1:0]; // [RL19]
        end
      end
    end
  end
endmodule // cimd_decoder
`default_nettype wire

// ### verif/cimd_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module cimd_contacts (
  input wire logic clk_i,
  output logic [21:0] c_o
);
  initial c_o = 22'h0;
  // Levels change only after an edge and are held for whole periods
  task put(input logic [21:0] v);
    @(posedge clk_i);
    c_o <= v;
  endtask
endmodule // cimd_contacts
`default_nettype wire

// ### verif/cimd_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cimd_decoder_chk (
  input wire clk_i,
  input wire rst_i,
  input wire synchronized_mode_i,
  input wire pattern_bit_method_i,
  input wire [7:0] display_colour_mode_i,
  input wire segment_wait_o,
  input wire tuning_start_o,
  input wire tuning_stop_o,
  input wire latch_clear_o,
  input wire colour_red_o,
  input wire [1:0] pattern_number_o,
  input wire key_pattern_change_enable_o,
  input wire sample_tick_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_wait; segment_wait_o |-> synchronized_mode_i; endproperty
  a_wait: assert property (p_wait) else $error("wait out of sync mode");
  property p_start; tuning_start_o |-> sample_tick_o && !tuning_stop_o; endproperty
  a_start: assert property (p_start) else $error("tuning start off sample");
  property p_stop; tuning_stop_o |-> sample_tick_o; endproperty
  a_stop: assert property (p_stop) else $error("tuning stop off sample");
  property p_clear; latch_clear_o |=> !latch_clear_o; endproperty
  a_clear: assert property (p_clear) else $error("latch clear too long");
  property p_clr_tick; latch_clear_o |-> sample_tick_o; endproperty
  a_clr_tick: assert property (p_clr_tick) else $error("latch clear off sample");
  property p_red; colour_red_o |-> display_colour_mode_i == 8'h0A; endproperty
  a_red: assert property (p_red) else $error("red in wrong mode");
  property p_pat; $changed(pattern_number_o) |-> sample_tick_o; endproperty
  a_pat: assert property (p_pat) else $error("pattern moved off sample");
  property p_lock; pattern_bit_method_i |-> !key_pattern_change_enable_o; endproperty
  a_lock: assert property (p_lock) else $error("key change open");
  c_start: cover property (tuning_start_o);
  c_clear: cover property (latch_clear_o);
  c_red: cover property (colour_red_o);
endmodule // cimd_decoder_chk
bind cimd_decoder cimd_decoder_chk i_cimd_decoder_chk (.*);
`default_nettype wire

// ### verif/test_cimd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_cimd_decoder;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  // Synchronized operation, so wait and hold contacts are meaningful
  logic sm = 1'b1, pm = 1'b0, qm = 1'b0;
  logic [2:0] pa = 3'h7, qa = 3'h7;
  logic [7:0] dcm = 8'h0A;
  logic ce = 1'b1;
  logic [3:0] zs = 4'h5;
  logic [21:0] c;
  logic segment_wait_o, segment_hold_o, key_hold_change_enable_o, auto_mode_o;
  logic key_auto_manual_enable_o, tuning_start_o, tuning_stop_o, latch_clear_o;
  logic backlight_on_o, colour_red_o, program_run_o, program_start_o, sample_tick_o;
  logic key_pattern_change_enable_o, key_pid_change_enable_o;
  logic [1:0] tuning_group_o, pattern_number_o, pid_group_o, local_pid_group_o;
  logic [2:0] message_shown_o;
  int bad_count = 0, checks_done = 0, n_ts = 0, n_tp = 0, n_lc = 0, n_ps = 0, n_tk = 0;
  int k;
  cimd_contacts i_cimd_contacts (.clk_i, .c_o(c));
  cimd_decoder #(.PERIOD_CYC(16)) i_cimd_decoder (.ce_i(ce), .wait_input_i(c[0]),
    .sync_hold_input_i(c[1]), .auto_manual_input_i(c[2]), .tuning_start_stop_input_i(c[3]),
    .latch_release_input_i(c[4]), .backlight_input_i(c[5]),
    .message_interrupt_inputs_i(c[9:6]), .value_colour_input_i(c[10]),
    .pattern_start_inputs_i(c[14:11]), .pattern_select_bits_i(c[17:15]),
    .pid_select_bits_i(c[20:18]), .display_key_i(c[21]), .pattern_select_assigned_i(pa),
    .pid_select_assigned_i(qa), .synchronized_mode_i(sm), .pattern_bit_method_i(pm),
    .pid_bit_method_i(qm), .display_colour_mode_i(dcm), .zone_pid_selection_i(zs), .*);
  initial forever #12.5 clk_i = ~clk_i;
  // Pulses last one cycle, so they are counted rather than sampled late
  always @(posedge clk_i)
  begin
    n_ts <= n_ts + tuning_start_o;
    n_tp <= n_tp + tuning_stop_o;
    n_lc <= n_lc + latch_clear_o;
    n_ps <= n_ps + program_start_o;
    n_tk <= n_tk + sample_tick_o;
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e, input string s);
  begin
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, s);
    end
  end
  endtask
  // Two samples after a change, since the sync stage can miss the first
  task step(input logic [21:0] v);
    int e;
  begin
    i_cimd_contacts.put(v);
    @(negedge clk_i);
    e = n_tk + 2;
    repeat (80) if (n_tk < e) @(negedge clk_i);
  end
  endtask
  task sel(input logic [2:0] b, input logic [1:0] e, input logic en);
  begin
    step({1'b0, b, b, 15'h0});
    chk({pattern_number_o, pid_group_o, local_pid_group_o, key_pattern_change_enable_o,
      key_pid_change_enable_o}, {e, e, e, en, en}, "select");
  end
  endtask
  task report_and_stop;
  begin
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  task t_levels;
  begin
    step(22'h407);
    chk({segment_wait_o, segment_hold_o, key_hold_change_enable_o, auto_mode_o,
      key_auto_manual_enable_o, colour_red_o}, 8'h35, "levels on");
    step(22'h0);
    chk({segment_wait_o, segment_hold_o, key_hold_change_enable_o, auto_mode_o,
      key_auto_manual_enable_o, colour_red_o}, 8'h0A, "levels off");
    @(posedge clk_i);
    dcm <= 8'h09;
    step(22'h401);
    chk({segment_wait_o, colour_red_o}, 8'h2, "colour mode");
    $display("levels done");
  end
  endtask
  task t_edges;
  begin
    step(22'h038);
    chk(n_ts, 1, "tune start");
    chk(n_lc, 1, "latch clear");
    chk(backlight_on_o, 0, "light off");
    chk(tuning_group_o, 0, "tune group");
    step(22'h0);
    chk(n_tp, 1, "tune stop");
    chk(n_lc + n_ts, 2, "extra pulse");
    chk(backlight_on_o, 1, "light on");
    @(posedge clk_i);
    sm <= 1'b0;
    step(22'h3);
    chk({segment_wait_o, segment_hold_o, key_hold_change_enable_o}, 1, "sync only");
    $display("edges done");
  end
  endtask
  task t_msg;
  begin
    step(22'h100);
    chk(message_shown_o, 3, "msg3");
    step(22'h300);
    chk(message_shown_o, 4, "msg4");
    step(22'h200300);
    chk(message_shown_o, 0, "erase");
    $display("message done");
  end
  endtask
  task t_sel;
  begin
    for (k = 1; k < 5; k++) sel(k[2:0], k - 1, 1'b0);
    sel(3'h0, 2'h3, 1'b1);
    sel(3'h5, 2'h3, 1'b0);
    @(posedge clk_i);
    pa <= 3'h6;
    qa <= 3'h6;
    sel(3'h1, 2'h3, 1'b1);
    @(posedge clk_i);
    pm <= 1'b1;
    qm <= 1'b1;
    pa <= 3'h7;
    qa <= 3'h7;
    for (k = 0; k < 4; k++) sel(k[2:0], k, 1'b0);
    @(posedge clk_i);
    zs <= 4'h0;
    step(22'h0);
    chk({pid_group_o, local_pid_group_o}, 8'h3, "zone off");
    $display("select done");
  end
  endtask
  task t_start;
  begin
    step(22'h1000);
    chk(n_ps, 1, "start pulse");
    chk({pattern_number_o, program_run_o}, 8'h3, "start pattern 2");
    step(22'h0);
    chk(program_run_o, 0, "run stops");
    $display("start done");
  end
  endtask
  task t_freeze;
    int m, n;
  begin
    @(posedge clk_i);
    ce <= 1'b0;
    i_cimd_contacts.put(22'h10);
    m = n_tk;
    n = n_lc;
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk(n_tk - m, 0, "frozen tick");
    chk(n_lc - n, 0, "frozen latch");
    @(posedge clk_i);
    ce <= 1'b1;
    step(22'h10);
    chk(n_lc - n, 1, "thawed latch");
    $display("freeze done");
  end
  endtask
  task t_power;
    int n;
  begin
    @(posedge clk_i);
    rst_i <= 1'b1;
    n = n_lc;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    step(22'h10);
    chk(n_lc - n, 1, "power-up edge");
    chk({pattern_number_o, pid_group_o, message_shown_o}, 0, "reset again");
    $display("power done");
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({pattern_number_o, pid_group_o, message_shown_o, backlight_on_o}, 8'h01, "reset");
    t_levels;
    t_edges;
    t_msg;
    t_sel;
    t_start;
    t_freeze;
    t_power;
    report_and_stop;
  end
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule // test_cimd_decoder
`default_nettype wire
